// [dv/partition_switch_sequencer_tb_top.sv]
/*
 Self-checking bench for the partition switch sequencer with the channel model.
 Assumes the sequencer answers on AXI4-Lite and saves five characters per switch.
*/
`include "pss_defs.svh"
module partition_switch_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, channel_release_strobe;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
	logic fc_zero = 1'b0;
	logic [31:0] s_axi_rdata, rd;
	logic [3:0] func_code, fc_cap, disc_state;
	pss_pkg::pss_mem_t mem_o;
	pss_pkg::pss_addr_t ad;
	logic on_cyl = 0, fault = 0, started, sd;
	logic [7:0] wa[$];
	logic [5:0] wd[$];
	int error_cnt = 0, comparisons = 0, n_strobe = 0, cyc = 0, seed, i;
	logic [31:0] ctl[3] = '{32'h19, 32'h9, 32'h1};

	pss_seq u_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.mem_o, .channel_release_strobe, .func_code, .irq);
	pss_chan_model u_chan (.clock, .rst, .channel_release_strobe, .on_cyl, .fault, .started, .disc_state);

	always #2 clock = ~clock;

	// Records saved characters, strobe pulses and the function code just after release
	always @(posedge clock) begin
		cyc++;
		if (mem_o.wr === 1'b1) begin
			wa.push_back(mem_o.addr);
			wd.push_back(mem_o.data);
		end
		if (channel_release_strobe === 1'b1)
			n_strobe++;
		sd <= channel_release_strobe;
		if (func_code === 4'h0)
			fc_zero <= 1'b1;
		if (sd === 1'b1)
			fc_cap <= func_code;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// Master write: address and data offered together, each released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		bit pa = 1;
		bit pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge clock);
			if (pa && s_axi_awready === 1'b1) begin
				pa = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready === 1'b1) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				bs = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic axr(input logic [11:0] a);
		bit pa = 1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge clock);
			if (pa && s_axi_arready === 1'b1) begin
				pa = 0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	// Starts one switch pass and waits for its five saved characters
	task automatic run(input logic [31:0] c);
		wa.delete();
		wd.delete();
		n_strobe = 0;
		axw(`PSS_OFF_CTRL, c);
		for (int n = 0; n < 300 && wa.size() < 5; n++)
			@(posedge clock);
		repeat (4) @(posedge clock);
		chk(wa.size(), 5, "save count");
	endtask

	task automatic chk_addrs(input logic [7:0] b, input logic t);
		for (int k = 0; k < 5; k++)
			chk(wa[k], t ? `PSS_TRAP_ADDR : b + 8'(k), "save address");
	endtask

	initial begin
		seed = 22587;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		chk(func_code, `PSS_FUNC_SWITCH, "function code");
		axr(`PSS_OFF_STAT);
		chk({rd[15:12], rd[10:8], rd[2:0]}, {4'h3, 3'h2, 3'h0}, "reset state");
		axr(12'h020);
		chk({rs, rd}, {2'h2, 32'h0}, "unmapped read");
		axw(12'h020, 32'h0);
		chk(bs, 2'h2, "unmapped write");
		$display("test reset done");
		wa.delete();
		axw(`PSS_OFF_CTRL, 32'h3);
		repeat (20) @(posedge clock);
		axr(`PSS_OFF_STAT);
		chk({wa.size() == 0, rd[10:8]}, {1'b1, 3'h2}, "supply hold");
		run(32'h1);
		chk_addrs(8'h08, 1'b0);
		chk(fc_zero, 1'b1, "function cleared");
		$display("test supply and advance done");
		ad = pss_pkg::pss_addr_t'($random(seed));
		ad.d0 = ad.d0 % 4'h9;
		axw(`PSS_OFF_ADDR_A, {8'h00, ad, 6'h00});
		on_cyl <= 1'b1;
		fault <= 1'b1;
		run(32'h5);
		chk({n_strobe == 1, started, disc_state, fc_cap}, {1'b1, 1'b1, 4'hA, `PSS_FUNC_INTERRUPT}, "release");
		chk_addrs(8'h08, 1'b0);
		chk({wd[1][3:0], wd[2][3:0], wd[3][3:0]}, {ad.d3, ad.d2, ad.d1}, "saved digits");
		axr(`PSS_OFF_IRQ_STAT);
		chk(rd[`PSS_IRQ_INACTIVE], ad.carry_bit, "inactive flag");
		$display("test channel copy done");
		for (i = 0; i < 3; i++) begin
			run(ctl[i]);
			chk_addrs(8'h18, ctl[i][`PSS_CTRL_TRAP]);
		end
		$display("test trap and hold done");
		axw(`PSS_OFF_IRQ_MASK, 32'h0);
		chk(irq, 1'b0, "irq masked");
		axw(`PSS_OFF_IRQ_MASK, 32'h1);
		chk(irq, 1'b1, "irq unmasked");
		axw(`PSS_OFF_IRQ_STAT, 32'h1);
		axr(`PSS_OFF_IRQ_STAT);
		chk({irq, rd[0]}, 2'b00, "irq cleared");
		$display("test interrupt done");
		wrap_up();
	end
endmodule // partition_switch_sequencer_tb_top

// [dv/pss_chan_model.sv]
/*
 Far-side file access channel model: starts its own operation on the release strobe.
 Assumes it shares the sequencer clock and reset.
*/
module pss_chan_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Sequencer side
	input wire logic channel_release_strobe,
	// Disc conditions
	input wire logic on_cyl,
	input wire logic fault,
	// Observed state
	output logic started,
	output logic [3:0] disc_state
);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			started <= 1'b0;
			disc_state <= 4'h0;
		end else if (channel_release_strobe) begin
			started <= 1'b1;
			disc_state <= (on_cyl && fault) ? 4'hA : 4'h1;
		end
	end
endmodule // pss_chan_model

// [hdl/pss_defs.svh]
/*
 Constants for the partition switch sequencer: register offsets, field positions,
 reset values and sequencer codes. Assumes inclusion by bare name.
*/
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_OFF_CTRL 12'h000
`define PSS_OFF_STAT 12'h004
`define PSS_OFF_IRQ_STAT 12'h008
`define PSS_OFF_IRQ_MASK 12'h00C
`define PSS_OFF_ADDR_A 12'h010
`define PSS_OFF_PADDR 12'h014
`define PSS_OFF_PART 12'h018
`define PSS_OFF_STORE 12'h01C
`define PSS_CTRL_GO 0
`define PSS_CTRL_SUPPLY 1
`define PSS_CTRL_BUSY 2
`define PSS_CTRL_TRAP 3
`define PSS_CTRL_HOLD 4
`define PSS_CTRL_FAULT 5
`define PSS_IRQ_RELEASE 0
`define PSS_IRQ_SAVED 1
`define PSS_IRQ_NEXT 2
`define PSS_IRQ_INACTIVE 3
`define PSS_FUNC_SWITCH 4'h3
`define PSS_FUNC_INTERRUPT 4'h2
`define PSS_FUNC_BEGIN 4'hA
`define PSS_TRAP_ADDR 8'h28
`define PSS_N_PATTERN 2'h1
`define PSS_SUB_LAST 3'h4
`define PSS_ADDR_RESET 18'h0_0000
`endif

// [hdl/pss_pkg.sv]
/*
 Types for the partition switch sequencer.
 Assumes pss_defs.svh supplies the numeric constants.
*/
package pss_pkg;
	typedef enum logic [2:0] {PSS_STEP0, PSS_STEP1, PSS_STEP2, PSS_STEP3, PSS_STEP4, PSS_DONE} pss_step_t;
	typedef struct packed {
		logic carry;
		logic minus;
		logic zero;
	} pss_flags_t;
	typedef struct packed {
		logic [3:0] d3;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
		logic carry_bit;
		logic bit5;
	} pss_addr_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [5:0] data;
	} pss_mem_t;
endpackage

// [hdl/pss_seq.sv]
/*
 Partition switch sequencer: steps 0 to 4 of the switch function with an AXI4-Lite
 register slave and one level interrupt. Assumes a single 250 MHz clock, inputs
 synchronous to it, and a core memory that accepts one character per cycle.
*/
`include "pss_defs.svh"
// How it works
// - Switch function is identified by function code 0011.
// - Step 0 drives flags and address to store bus; sub-step 0 adds limit, increment, N=01.
// - Sub-steps 1..4 pair digits 3..0 with carry, minus, zero, address carry bit.
// - Saved lowest digit flag one marks the partition inactive.
// - Step 1 writes core, advances sub-step, trap uses location 40, loops until sub-step 4.
// - Step 2 holds while supply loss flag is set.
// - Reset enters step 2 and clears sub-step, busy, partition and fault.
// - Step 3 copies A digits 3,2,1 at sub-steps 1,2,3 while busy.
// - Sub-step 4 copies digit 0, carry bit and bit 5.
// - After sub-step 4 pulse release strobe, set interrupt function code and jump to step PSS_DONE.
// - Release strobe frees the file access channel, which then starts.
// - Step 4 clears expiry, disc access, function register, index pair, loads Z.
// - Step 4 advances partition and H unless rotation hold and trap both set.
// - Actions are enable, preset, clear, toggle, load or jump.
// - Write command when storing into core, read command when fetching; the sequencer never fetches, so mem_o.rd stays 0.
// - State is function plus step, subdivided by sub-step counter.
// - With no jump, go to next step of the same function.
module pss_seq (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core memory and channel
	output pss_pkg::pss_mem_t mem_o,
	output logic channel_release_strobe,
	output logic [3:0] func_code,
	// Interrupt
	output logic irq
);
	pss_pkg::pss_step_t step_r;
	logic [2:0] sub_r;
	logic [3:0] func_r;
	logic [7:0] ctrl_r;
	logic [3:0] irq_stat_r, irq_mask_r, irq_ev;
	pss_pkg::pss_addr_t addr_a_r, paddr_r;
	pss_pkg::pss_flags_t flags_r;
	logic [7:0] part_r, h_r;
	logic [5:0] store_r;
	logic [1:0] n_bits_r;
	logic expiry_r, disc_access_r, fault_r;
	logic [1:0] index_pair_r;
	logic [7:0] z_r;
	logic aw_hold_r, w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go, wr_ok;
	logic supply, busy, trap, hold;
	logic [5:0] ch;

	assign supply = ctrl_r[`PSS_CTRL_SUPPLY];
	assign busy = ctrl_r[`PSS_CTRL_BUSY];
	assign trap = ctrl_r[`PSS_CTRL_TRAP];
	assign hold = ctrl_r[`PSS_CTRL_HOLD];

	// Write channel: address and data may arrive in either order
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wr_ok = awaddr_r[11:2] <= `PSS_OFF_STORE >> 2;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			unique case ({s_axi_araddr[11:2], 2'b00})
				`PSS_OFF_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_r};
				`PSS_OFF_STAT: s_axi_rdata <= {16'h0000, func_r, 1'b0, step_r, 3'b000, fault_r, 1'b0, sub_r};
				`PSS_OFF_IRQ_STAT: s_axi_rdata <= {28'h000_0000, irq_stat_r};
				`PSS_OFF_IRQ_MASK: s_axi_rdata <= {28'h000_0000, irq_mask_r};
				`PSS_OFF_ADDR_A: s_axi_rdata <= {8'h00, addr_a_r[17:0], 6'h00};
				`PSS_OFF_PADDR: s_axi_rdata <= {8'h00, paddr_r[17:0], 3'b000, flags_r};
				`PSS_OFF_PART: s_axi_rdata <= {16'h0000, h_r, part_r};
				`PSS_OFF_STORE: s_axi_rdata <= {24'h00_0000, n_bits_r, store_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control, A address and flags written by software; go cleared once step reaches PSS_DONE
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_r <= 8'h00;
			addr_a_r <= '0;
			flags_r <= '0;
		end else begin
			if (wr_go && wstrb_r[0]) begin
				unique case ({awaddr_r[11:2], 2'b00})
					`PSS_OFF_CTRL: ctrl_r <= wdata_r[7:0];
					`PSS_OFF_ADDR_A: addr_a_r <= wdata_r[23:6];
					`PSS_OFF_PADDR: flags_r <= wdata_r[2:0];
					default: ;
				endcase
			end else if (ctrl_r[`PSS_CTRL_GO] && step_r == pss_pkg::PSS_DONE) begin
				ctrl_r[`PSS_CTRL_GO] <= 1'b0;
			end
		end
	end

	// Character selected by sub-step for the save sequence
	always_comb begin
		unique case (sub_r)
			3'd0: ch = {2'b00, part_r[3:0]};
			3'd1: ch = {flags_r.carry, 1'b0, paddr_r.d3};
			3'd2: ch = {flags_r.minus, 1'b0, paddr_r.d2};
			3'd3: ch = {flags_r.zero, 1'b0, paddr_r.d1};
			default: ch = {paddr_r.carry_bit, paddr_r.bit5, paddr_r.d0};
		endcase
	end

	// Sequencer: function code plus step, subdivided by sub-step
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_r <= pss_pkg::PSS_STEP2;
			func_r <= `PSS_FUNC_SWITCH;
			sub_r <= 3'd0;
			paddr_r <= `PSS_ADDR_RESET;
			part_r <= 8'h00;
			h_r <= 8'h00;
			fault_r <= 1'b0;
			store_r <= 6'h00;
			n_bits_r <= 2'b00;
			mem_o <= '0;
			channel_release_strobe <= 1'b0;
			expiry_r <= 1'b1;
			disc_access_r <= 1'b1;
			index_pair_r <= 2'b11;
			z_r <= 8'h00;
		end else begin
			mem_o.wr <= 1'b0;
			mem_o.rd <= 1'b0;
			channel_release_strobe <= 1'b0;
			if (ctrl_r[`PSS_CTRL_FAULT])
				fault_r <= 1'b1;
			unique case (step_r)
				pss_pkg::PSS_STEP0: begin
					store_r <= ch;
					if (sub_r == 3'd0) begin
						n_bits_r <= `PSS_N_PATTERN;
						paddr_r.d0 <= paddr_r.d0 + 4'h1;
					end
					step_r <= pss_pkg::PSS_STEP1;
				end
				pss_pkg::PSS_STEP1: begin
					mem_o.wr <= 1'b1;
					mem_o.data <= store_r;
					mem_o.addr <= trap ? `PSS_TRAP_ADDR : {part_r[4:0], sub_r};
					sub_r <= sub_r + 3'd1;
					if (sub_r != `PSS_SUB_LAST)
						step_r <= pss_pkg::PSS_STEP0;
					else begin
						sub_r <= 3'd0;
						step_r <= pss_pkg::PSS_STEP2;
					end
				end
				pss_pkg::PSS_STEP2: begin
					if (!supply && ctrl_r[`PSS_CTRL_GO])
						step_r <= pss_pkg::PSS_STEP3;
				end
				pss_pkg::PSS_STEP3: begin
					if (busy) begin
						sub_r <= sub_r + 3'd1;
						unique case (sub_r)
							3'd1: paddr_r.d3 <= addr_a_r.d3;
							3'd2: paddr_r.d2 <= addr_a_r.d2;
							3'd3: paddr_r.d1 <= addr_a_r.d1;
							3'd4: begin
								paddr_r.d0 <= addr_a_r.d0;
								paddr_r.carry_bit <= addr_a_r.carry_bit;
								paddr_r.bit5 <= addr_a_r.bit5;
								channel_release_strobe <= 1'b1;
								func_r <= `PSS_FUNC_INTERRUPT;
								sub_r <= 3'd0;
								step_r <= pss_pkg::PSS_DONE;
							end
							default: ;
						endcase
					end else
						step_r <= pss_pkg::PSS_STEP4;
				end
				pss_pkg::PSS_STEP4: begin
					expiry_r <= 1'b0;
					disc_access_r <= 1'b0;
					index_pair_r <= 2'b00;
					func_r <= 4'h0;
					z_r <= part_r;
					if (!(hold && trap)) begin
						part_r <= part_r + 8'h01;
						h_r <= h_r + 8'h01;
					end
					step_r <= pss_pkg::PSS_DONE;
				end
				default: begin
					if (!ctrl_r[`PSS_CTRL_GO]) begin
						func_r <= `PSS_FUNC_SWITCH;
						step_r <= pss_pkg::PSS_STEP0;
					end
				end
			endcase
		end
	end

	assign func_code = func_r;

	// Sticky events, write one to clear, set wins
	assign irq_ev[`PSS_IRQ_RELEASE] = channel_release_strobe;
	assign irq_ev[`PSS_IRQ_SAVED] = mem_o.wr && mem_o.data[5] && sub_r == 3'd0;
	assign irq_ev[`PSS_IRQ_NEXT] = step_r == pss_pkg::PSS_STEP4;
	assign irq_ev[`PSS_IRQ_INACTIVE] = mem_o.wr && mem_o.data[5] && sub_r == 3'd0;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat_r <= 4'h0;
			irq_mask_r <= 4'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr_go && awaddr_r[11:2] == `PSS_OFF_IRQ_STAT >> 2) ?
				wdata_r[3:0] : 4'h0)) | irq_ev;
			if (wr_go && awaddr_r[11:2] == `PSS_OFF_IRQ_MASK >> 2)
				irq_mask_r <= wdata_r[3:0];
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	step_hold_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP2 && supply |=> step_r == pss_pkg::PSS_STEP2)
		else $error("Step 2 left during supply loss");
	release_jump_a: assert property (@(posedge clock) disable iff (rst)
		channel_release_strobe |-> func_r == `PSS_FUNC_INTERRUPT && $past(sub_r) == 3'd4)
		else $error("Release without interrupt jump");
	save_write_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP1 |=> mem_o.wr && !mem_o.rd)
		else $error("Step 1 without core write");
	trap_addr_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP1 && trap |=> mem_o.addr == `PSS_TRAP_ADDR)
		else $error("Trap save not at 40");
	save_loop_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP1 && sub_r < 3'd4 |=> step_r == pss_pkg::PSS_STEP0)
		else $error("Save loop broken");
	copy_d3_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP3 && busy && sub_r == 3'd1 |=> paddr_r.d3 == $past(addr_a_r.d3))
		else $error("Digit 3 not copied");
	part_next_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP4 && !(hold && trap) |=> part_r == $past(part_r) + 8'h01)
		else $error("Partition not advanced");
	part_keep_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP4 && hold && trap |=> $stable(part_r))
		else $error("Partition moved under hold");
	n_pattern_a: assert property (@(posedge clock) disable iff (rst)
		step_r == pss_pkg::PSS_STEP0 && sub_r == 3'd0 |=> n_bits_r == `PSS_N_PATTERN)
		else $error("N bits not 01");
	release_c: cover property (@(posedge clock) disable iff (rst) channel_release_strobe);
	advance_c: cover property (@(posedge clock) disable iff (rst) step_r == pss_pkg::PSS_STEP4);
	save_c: cover property (@(posedge clock) disable iff (rst) mem_o.wr && sub_r == 3'd0);
endmodule // pss_seq
